// File: pmc_power_mode_controller.sv
// Power mode controller top level
// Function
// - Reset always returns to active, CPU running
// - Reset and interrupts both wake chip
// - Sleep gates off the CPU clock
// - Enabled peripheral clocks keep running in sleep
// - Sleep keeps state, memory, pins held
// - PD0 powers only always-on, oscillators, timers
// - PD0 stops clocks, optional 32k kept
// - PD0 flash/analog off, comparator optional wake
// - PD0 wakes from seven listed sources
// - PD0 retains state; slower wake allowed
// - PD1 drops 32k; pins, comparator wake
// - Brownout detector off until software enables
`timescale 1ns/1ps
`default_nettype none
`include "pmc_params.svh"
module pmc_power_mode_controller #(
    parameter int SETTLE_CYCLES = `PMC_SETTLE_CYCLES
) (
    input  wire logic                 CORE_CLK,
    input  wire logic                 RST,
    input  wire pmc_pkg::pmc_req_type MODE_REQ,
    input  wire logic                 MODE_REQ_VALID,
    input  wire logic                 PERIPH_CLK_SEL,
    input  wire logic                 KEEP_32K,
    input  wire logic                 COMP_KEEP,
    input  wire logic                 EXTERNAL_RESET_PIN_N,
    input  wire logic                 PIN_IRQ,
    input  wire logic                 STIMER_IRQ,
    input  wire logic                 RTC_IRQ,
    input  wire logic                 COMP_ABOVE_REF,
    input  wire logic                 CAP_IRQ,
    input  wire logic                 PERIPH_IRQ,
    input  wire logic                 BROWNOUT_DETECTOR_EN,
    input  wire logic                 BROWNOUT_DETECTOR_TRIP,
    input  wire logic                 BROWNOUT_RESET_SEL,
    output pmc_pkg::pmc_gate_type     GATES,
    output logic [1:0]                MODE,
    output logic                      WAKE,
    output logic                      BROWNOUT_FLAG,
    output logic                      BROWNOUT_RESET
);
    import pmc_pkg::*;

    if (SETTLE_CYCLES < 1) begin : g_bad_settle
        $error("SETTLE_CYCLES must be at least one");
    end

    //------------------------------------------------------------
    // Mode state
    //------------------------------------------------------------
    typedef enum logic [2:0] {ST_ACTIVE, ST_SLEEP, ST_PD0, ST_PD1, ST_RESTORE} pmc_state_type;
    pmc_state_type state;
    pmc_state_type next_state;
    logic [7:0]    wake_src;
    logic [7:0]    wake_mask;
    logic          wake_hit;
    logic          settle_start;
    logic          settle_done;
    logic          brown_event;

    // Brownout acts only once software turns it on
    assign brown_event = BROWNOUT_DETECTOR_EN & BROWNOUT_DETECTOR_TRIP & BROWNOUT_RESET_SEL;

    // Gather wake sources, reset and interrupts alike
    always_comb begin
        wake_src = 8'h00;
        wake_src[`PMC_WK_RESET]  = ~EXTERNAL_RESET_PIN_N;
        wake_src[`PMC_WK_PIN]    = PIN_IRQ;
        wake_src[`PMC_WK_STIMER] = STIMER_IRQ;
        wake_src[`PMC_WK_RTC]    = RTC_IRQ;
        wake_src[`PMC_WK_BROWN]  = brown_event;
        wake_src[`PMC_WK_COMP]   = COMP_ABOVE_REF & COMP_KEEP;
        wake_src[`PMC_WK_CAP]    = CAP_IRQ;
        wake_src[`PMC_WK_PERIPH] = PERIPH_IRQ & PERIPH_CLK_SEL;
    end

    // Allowed sources per reduced mode
    always_comb begin
        case (state)
            ST_SLEEP: wake_mask = `PMC_SLEEP_WAKE_MASK;
            ST_PD0:   wake_mask = `PMC_PD0_WAKE_MASK;
            ST_PD1:   wake_mask = `PMC_PD1_WAKE_MASK;
            default:  wake_mask = 8'h00;
        endcase
    end
    assign wake_hit = |(wake_src & wake_mask);

    // Next mode selection
    always_comb begin
        next_state   = state;
        settle_start = 1'b0;
        case (state)
            ST_ACTIVE: begin
                if (MODE_REQ_VALID) begin
                    case (MODE_REQ)
                        PMC_REQ_SLEEP: next_state = ST_SLEEP;
                        PMC_REQ_PD0:   next_state = ST_PD0;
                        PMC_REQ_PD1:   next_state = ST_PD1;
                        default:       next_state = ST_ACTIVE;
                    endcase
                end
            end
            ST_SLEEP: begin
                if (wake_hit) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_PD0, ST_PD1: begin
                if (wake_hit) begin
                    next_state   = ST_RESTORE;
                    settle_start = 1'b1;
                end
            end
            ST_RESTORE: begin
                if (settle_done) begin
                    next_state = ST_ACTIVE;
                end
            end
            default: next_state = ST_ACTIVE;
        endcase
    end

    // Mode register, active after reset
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            state <= ST_ACTIVE;
        end else begin
            state <= next_state;
        end
    end

    // Settling of restored domains
    pmc_settle #(
        .CYCLES (SETTLE_CYCLES)
    ) u_settle (
        .clk   (CORE_CLK),
        .rst   (RST),
        .start (settle_start),
        .done  (settle_done)
    );

    //------------------------------------------------------------
    // Gate outputs
    //------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            GATES <= '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, clk32k_en: 1'b1, flash_pwr: 1'b1,
                       analog_pwr: 1'b1, main_pwr: 1'b1, comp_pwr: 1'b1, timer_rtc_pwr: 1'b1,
                       pin_hold: 1'b0};
        end else begin
            case (next_state)
                ST_SLEEP: begin
                    GATES.cpu_clk_en    <= 1'b0;
                    GATES.periph_clk_en <= PERIPH_CLK_SEL;
                    GATES.clk32k_en     <= 1'b1;
                    GATES.flash_pwr     <= 1'b1;
                    GATES.analog_pwr    <= 1'b1;
                    GATES.main_pwr      <= 1'b1;
                    GATES.comp_pwr      <= 1'b1;
                    GATES.timer_rtc_pwr <= 1'b1;
                    GATES.pin_hold      <= 1'b1;
                end
                ST_PD0: begin
                    GATES.cpu_clk_en    <= 1'b0;
                    GATES.periph_clk_en <= 1'b0;
                    GATES.clk32k_en     <= KEEP_32K;
                    GATES.flash_pwr     <= 1'b0;
                    GATES.analog_pwr    <= 1'b0;
                    GATES.main_pwr      <= 1'b0;
                    GATES.comp_pwr      <= COMP_KEEP;
                    GATES.timer_rtc_pwr <= 1'b1;
                    GATES.pin_hold      <= 1'b1;
                end
                ST_PD1: begin
                    GATES.cpu_clk_en    <= 1'b0;
                    GATES.periph_clk_en <= 1'b0;
                    GATES.clk32k_en     <= 1'b0;
                    GATES.flash_pwr     <= 1'b0;
                    GATES.analog_pwr    <= 1'b0;
                    GATES.main_pwr      <= 1'b0;
                    GATES.comp_pwr      <= COMP_KEEP;
                    GATES.timer_rtc_pwr <= 1'b0;
                    GATES.pin_hold      <= 1'b1;
                end
                ST_RESTORE: begin
                    GATES.cpu_clk_en    <= 1'b0;
                    GATES.periph_clk_en <= 1'b1;
                    GATES.clk32k_en     <= 1'b1;
                    GATES.flash_pwr     <= 1'b1;
                    GATES.analog_pwr    <= 1'b1;
                    GATES.main_pwr      <= 1'b1;
                    GATES.comp_pwr      <= 1'b1;
                    GATES.timer_rtc_pwr <= 1'b1;
                    GATES.pin_hold      <= 1'b1;
                end
                default: begin
                    GATES.cpu_clk_en    <= 1'b1;
                    GATES.periph_clk_en <= 1'b1;
                    GATES.clk32k_en     <= 1'b1;
                    GATES.flash_pwr     <= 1'b1;
                    GATES.analog_pwr    <= 1'b1;
                    GATES.main_pwr      <= 1'b1;
                    GATES.comp_pwr      <= 1'b1;
                    GATES.timer_rtc_pwr <= 1'b1;
                    GATES.pin_hold      <= 1'b0;
                end
            endcase
        end
    end

    // Mode code, wake pulse and brownout outputs
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            MODE           <= 2'h0;
            WAKE           <= 1'b0;
            BROWNOUT_FLAG  <= 1'b0;
            BROWNOUT_RESET <= 1'b0;
        end else begin
            case (next_state)
                ST_SLEEP: MODE <= 2'h1;
                ST_PD0:   MODE <= 2'h2;
                ST_PD1:   MODE <= 2'h3;
                default:  MODE <= 2'h0;
            endcase
            WAKE           <= (state != ST_ACTIVE) && (next_state == ST_ACTIVE);
            BROWNOUT_FLAG  <= BROWNOUT_DETECTOR_EN & BROWNOUT_DETECTOR_TRIP;
            BROWNOUT_RESET <= brown_event;
        end
    end

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    property p_reset_active;
        @(posedge CORE_CLK) RST |=> (MODE == 2'h0) && GATES.cpu_clk_en;
    endproperty
    a_reset_active: assert property (p_reset_active) else $error("not active after reset");

    property p_leave_on_request;
        @(posedge CORE_CLK) disable iff (RST)
            (state == ST_ACTIVE && !MODE_REQ_VALID) |=> state == ST_ACTIVE;
    endproperty
    a_leave_on_request: assert property (p_leave_on_request) else $error("left active without request");

    property p_sleep_wake;
        @(posedge CORE_CLK) disable iff (RST)
            (state == ST_SLEEP && PIN_IRQ) |=> state == ST_ACTIVE && WAKE;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("pin interrupt did not wake sleep");

    property p_sleep_cpu_off;
        @(posedge CORE_CLK) disable iff (RST)
            (state == ST_ACTIVE && MODE_REQ_VALID && MODE_REQ == PMC_REQ_SLEEP)
                |=> !GATES.cpu_clk_en && GATES.pin_hold && GATES.main_pwr;
    endproperty
    a_sleep_cpu_off: assert property (p_sleep_cpu_off) else $error("sleep gating wrong");

    property p_pd0_gates;
        @(posedge CORE_CLK) disable iff (RST)
            (state == ST_PD0 && !wake_hit) |=> !GATES.main_pwr && !GATES.flash_pwr
                && GATES.timer_rtc_pwr && GATES.clk32k_en == $past(KEEP_32K);
    endproperty
    a_pd0_gates: assert property (p_pd0_gates) else $error("power-down 0 gating wrong");

    property p_pd1_no_rtc_wake;
        @(posedge CORE_CLK) disable iff (RST)
            (state == ST_PD1 && (wake_src & 8'hDC) == wake_src) |=> state == ST_PD1;
    endproperty
    a_pd1_no_rtc_wake: assert property (p_pd1_no_rtc_wake) else $error("power-down 1 woke on bad source");

    sequence s_restore;
        state == ST_RESTORE && !GATES.cpu_clk_en;
    endsequence
    property p_restore_then_active;
        @(posedge CORE_CLK) disable iff (RST)
            ((state == ST_PD0 || state == ST_PD1) && wake_hit) |=> s_restore ##[1:300] state == ST_ACTIVE;
    endproperty
    a_restore_then_active: assert property (p_restore_then_active) else $error("restore did not finish");

    property p_brownout_off;
        @(posedge CORE_CLK) disable iff (RST)
            !BROWNOUT_DETECTOR_EN |=> !BROWNOUT_RESET && !BROWNOUT_FLAG;
    endproperty
    a_brownout_off: assert property (p_brownout_off) else $error("brownout acted while off");
endmodule : pmc_power_mode_controller
`default_nettype wire

// File: pmc_params.svh
// Constants of the power mode controller
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH
// Wake source bit positions
`define PMC_WK_RESET   0
`define PMC_WK_PIN     1
`define PMC_WK_STIMER  2
`define PMC_WK_RTC     3
`define PMC_WK_BROWN   4
`define PMC_WK_COMP    5
`define PMC_WK_CAP     6
`define PMC_WK_PERIPH  7
// Wake sources allowed per reduced mode
`define PMC_SLEEP_WAKE_MASK 8'hFF
`define PMC_PD0_WAKE_MASK   8'h7F
`define PMC_PD1_WAKE_MASK   8'h23
// Domain restore settling time
`define PMC_SETTLE_NS       50
`define PMC_SETTLE_CYCLES   ((`PMC_SETTLE_NS + 9) / 10)
`endif

// File: pmc_pkg.sv
// Types of the power mode controller
`default_nettype none
package pmc_pkg;
    typedef enum logic [1:0] {
        PMC_REQ_SLEEP,
        PMC_REQ_PD0,
        PMC_REQ_PD1,
        PMC_REQ_NONE
    } pmc_req_type;

    typedef struct packed {
        logic cpu_clk_en;
        logic periph_clk_en;
        logic clk32k_en;
        logic flash_pwr;
        logic analog_pwr;
        logic main_pwr;
        logic comp_pwr;
        logic timer_rtc_pwr;
        logic pin_hold;
    } pmc_gate_type;
endpackage : pmc_pkg
`default_nettype wire

// File: pmc_settle.sv
// Settling counter used when domains are restored
`timescale 1ns/1ps
`default_nettype none
module pmc_settle #(
    parameter int CYCLES = 5
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic start,
    output logic      done
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] count;

    if (CYCLES < 1) begin : g_bad_cycles
        $error("CYCLES must be at least one");
    end

    // Loads on start, counts down, reports done at zero
    always_ff @(posedge clk) begin
        if (rst) begin
            count <= '0;
            done  <= 1'b0;
        end else if (start) begin
            count <= W'(CYCLES);
            done  <= 1'b0;
        end else if (count != '0) begin
            count <= count - 1'b1;
            done  <= (count == W'(1));
        end else begin
            done  <= 1'b0;
        end
    end
endmodule : pmc_settle
`default_nettype wire

// File: pmc_sw_model.sv
// Model of processor software and wake sources facing the controller
`timescale 1ns/1ps
`default_nettype none
module pmc_sw_model (
    input  wire logic         clk,
    output pmc_pkg::pmc_req_type req,
    output logic              req_valid,
    output logic [7:0]        src,
    output logic              bo_en,
    output logic              bo_sel
);
    import pmc_pkg::*;

    // ----------------------------------------
    // Idle levels: no request, no wake source
    // ----------------------------------------
    initial begin
        req = PMC_REQ_NONE;
        req_valid = 1'b0;
        src = 8'h00;
        bo_en = 1'b0;
        bo_sel = 1'b0;
    end

    // One-cycle mode request from software after its work is done
    task automatic request(input pmc_req_type m);
        @(negedge clk);
        req = m;
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        req = PMC_REQ_NONE;
    endtask : request

    // One-cycle wake event; brownout source also arms the forced reset
    task automatic pulse(input int idx);
        @(negedge clk);
        src[idx] = 1'b1;
        if (idx == 4) begin
            bo_en = 1'b1;
            bo_sel = 1'b1;
        end
        @(negedge clk);
        src = 8'h00;
        bo_en = 1'b0;
        bo_sel = 1'b0;
    endtask : pulse

    // Brownout detector levels set by software and supply
    task automatic brown(input logic en, input logic trip, input logic sel);
        @(negedge clk);
        bo_en = en;
        src[4] = trip;
        bo_sel = sel;
    endtask : brown
endmodule : pmc_sw_model
`default_nettype wire

// File: testbench.sv
// Self-checking testbench of the power mode controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pmc_pkg::*;
    typedef struct {logic [1:0] mode; logic [8:0] val; logic [8:0] mask;} pmc_note_type;
    typedef struct {int lo; int hi;} pmc_win_type;

    logic CORE_CLK, RST, PERIPH_CLK_SEL, KEEP_32K, COMP_KEEP;
    logic MODE_REQ_VALID, BO_EN, BO_SEL, WAKE, BROWNOUT_FLAG, BROWNOUT_RESET;
    pmc_req_type   MODE_REQ;
    pmc_gate_type  GATES;
    logic [1:0]    MODE, prev_mode;
    logic [7:0]    SRC;
    logic [31:0]   seed = 32'hA85ADD39;
    int            n_errors = 0, tests_run = 0, cyc = 0, t_evt = 0;
    pmc_note_type  mq[$];
    pmc_win_type   wq[$];

    pmc_sw_model i_pmc_sw_model (.clk(CORE_CLK), .req(MODE_REQ), .req_valid(MODE_REQ_VALID),
        .src(SRC), .bo_en(BO_EN), .bo_sel(BO_SEL));

    pmc_power_mode_controller #(.SETTLE_CYCLES(1)) i_pmc_power_mode_controller (
        .CORE_CLK(CORE_CLK), .RST(RST), .MODE_REQ(MODE_REQ), .MODE_REQ_VALID(MODE_REQ_VALID),
        .PERIPH_CLK_SEL(PERIPH_CLK_SEL), .KEEP_32K(KEEP_32K), .COMP_KEEP(COMP_KEEP),
        .EXTERNAL_RESET_PIN_N(~SRC[0]), .PIN_IRQ(SRC[1]), .STIMER_IRQ(SRC[2]), .RTC_IRQ(SRC[3]),
        .COMP_ABOVE_REF(SRC[5]), .CAP_IRQ(SRC[6]), .PERIPH_IRQ(SRC[7]),
        .BROWNOUT_DETECTOR_EN(BO_EN), .BROWNOUT_DETECTOR_TRIP(SRC[4]), .BROWNOUT_RESET_SEL(BO_SEL),
        .GATES(GATES), .MODE(MODE), .WAKE(WAKE), .BROWNOUT_FLAG(BROWNOUT_FLAG),
        .BROWNOUT_RESET(BROWNOUT_RESET));

    // ----------------------------------------
    // Clock, cycle count and helpers
    // ----------------------------------------
    initial CORE_CLK = 1'b0;
    always #5 CORE_CLK = ~CORE_CLK;
    always @(posedge CORE_CLK) cyc <= cyc + 1;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Compare and report one value
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Gate pattern expected on entry to a reduced mode
    function automatic pmc_note_type enter_note(input pmc_req_type m);
        pmc_note_type n;
        logic sl, p0, p1;
        sl = (m == PMC_REQ_SLEEP);
        p0 = (m == PMC_REQ_PD0);
        p1 = (m == PMC_REQ_PD1);
        n.mode = 2'(m) + 2'h1;
        n.val = {1'b0, PERIPH_CLK_SEL & sl, (KEEP_32K & p0) | sl, {3{sl}}, COMP_KEEP | sl, !p1, 1'b1};
        n.mask = 9'h1FF;
        return n;
    endfunction : enter_note

    task automatic final_report;
        $display("errors=%0d checks=%0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------
    // Monitor: mode changes and wake pulses
    // ----------------------------------------
    always @(negedge CORE_CLK) begin : mon
        pmc_note_type n;
        pmc_win_type w;
        int lat;
        if (RST) begin
            prev_mode = 2'h0;
        end else begin
            if (MODE !== prev_mode) begin
                if (mq.size() == 0) begin
                    check(9'(MODE), 9'(prev_mode));
                end else begin
                    n = mq.pop_front();
                    check(9'(MODE), 9'(n.mode));
                    check(GATES & n.mask, n.val);
                end
            end
            if (WAKE === 1'b1) begin
                if (wq.size() == 0) begin
                    check(9'h001, 9'h000);
                end else begin
                    w = wq.pop_front();
                    lat = cyc - t_evt;
                    check((lat >= w.lo && lat <= w.hi) ? 9'(w.lo) : 9'(lat), 9'(w.lo));
                    check(GATES, 9'h1FE);
                    check(9'(MODE), 9'h000);
                end
            end
            prev_mode = MODE;
        end
    end

    // One trip through a reduced mode, with refused traffic inside it
    task automatic run(input pmc_req_type m, input int s);
        int bad[$];
        if (m == PMC_REQ_PD0) bad = {7};
        else if (m == PMC_REQ_PD1) bad = {2, 3, 4, 6, 7};
        seed = lfsr(seed);
        @(negedge CORE_CLK);
        PERIPH_CLK_SEL = seed[0] | (s == 7);
        KEEP_32K = seed[1];
        COMP_KEEP = seed[2] | (s == 5);
        mq.push_back(enter_note(m));
        i_pmc_sw_model.request(m);
        repeat (1 + seed[5:4]) @(negedge CORE_CLK);
        i_pmc_sw_model.request(PMC_REQ_PD1);
        foreach (bad[i]) i_pmc_sw_model.pulse(bad[i]);
        repeat (3) @(negedge CORE_CLK);
        wq.push_back(pmc_win_type'{(m == PMC_REQ_SLEEP) ? 1 : 3, (m == PMC_REQ_SLEEP) ? 2 : 7});
        mq.push_back('{2'h0, {m == PMC_REQ_SLEEP, 4'h0, 1'b1, 3'h0}, 9'h108});
        t_evt = cyc + 1;
        i_pmc_sw_model.pulse(s);
        repeat (12) @(negedge CORE_CLK);
    endtask : run

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        RST = 1'b1;
        PERIPH_CLK_SEL = 1'b0;
        KEEP_32K = 1'b0;
        COMP_KEEP = 1'b0;
        repeat (3) @(negedge CORE_CLK);
        RST = 1'b0;
        @(negedge CORE_CLK);
        check(GATES, 9'h1FE);
        check({6'h00, MODE, WAKE}, 9'h000);
        check({7'h00, BROWNOUT_FLAG, BROWNOUT_RESET}, 9'h000);
        i_pmc_sw_model.request(PMC_REQ_NONE);
        repeat (3) @(negedge CORE_CLK);
        for (int s = 0; s < 8; s++) run(PMC_REQ_SLEEP, s);
        for (int s = 0; s < 7; s++) run(PMC_REQ_PD0, s);
        for (int s = 0; s < 6; s++) if (s < 2 || s == 5) run(PMC_REQ_PD1, s);
        // Reset in the middle of power-down 1 must bring back active mode
        mq.push_back(enter_note(PMC_REQ_PD1));
        i_pmc_sw_model.request(PMC_REQ_PD1);
        @(negedge CORE_CLK);
        RST = 1'b1;
        repeat (2) @(negedge CORE_CLK);
        RST = 1'b0;
        check(GATES, 9'h1FE);
        check({6'h00, MODE, WAKE}, 9'h000);
        repeat (2) @(negedge CORE_CLK);
        i_pmc_sw_model.brown(1'b0, 1'b1, 1'b1);
        repeat (2) @(negedge CORE_CLK);
        check({BROWNOUT_FLAG, BROWNOUT_RESET}, 9'h000);
        i_pmc_sw_model.brown(1'b1, 1'b1, 1'b0);
        repeat (2) @(negedge CORE_CLK);
        check({BROWNOUT_FLAG, BROWNOUT_RESET}, 9'h002);
        i_pmc_sw_model.brown(1'b1, 1'b1, 1'b1);
        repeat (2) @(negedge CORE_CLK);
        check({BROWNOUT_FLAG, BROWNOUT_RESET}, 9'h003);
        i_pmc_sw_model.brown(1'b0, 1'b0, 1'b0);
        repeat (4) @(negedge CORE_CLK);
        check(9'(mq.size() + wq.size()), 9'h000);
        final_report();
    end

    // Watchdog sized well beyond the expected run of about 500 cycles
    initial begin
        #40000;
        n_errors++;
        final_report();
    end
endmodule : testbench
`default_nettype wire
